//--- hdl/sbp_pkg.sv
package sbp_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    // Byte addresses of the register words
    localparam logic [ADDR_W-1:0] PRESCALER_ADDR = 32'h0ffff340;
    localparam logic [ADDR_W-1:0] CLKSEL_ADDR = 32'h0ffff344;
    localparam logic [ADDR_W-1:0] EXPAND_ADDR = 32'h0ffff348;
    localparam logic [ADDR_W-1:0] OPTION_ADDR = 32'h0ffff34c;
    // Prescaler select fields
    localparam int ENABLE_BIT = 4;
    localparam int HIGH_BIT = 3;
    localparam int RATIO_LSB = 0;
    localparam logic [7:0] PRESCALER_RESET = 8'h00;
    localparam logic [7:0] PRESCALER_WMASK = 8'h1b;
    // Clock select, clock extension and option bit fields
    localparam int SPEED_BIT = 3;
    localparam int CLKSEL_LSB = 0;
    localparam logic [7:0] CLKSEL_WMASK = 8'h0b;
    localparam int EXT_BIT = 0;
    localparam int OPTION_BIT = 0;
    // Second stage divisors
    localparam logic [7:0] DIV_SEL0 = 8'h2c;
    localparam logic [7:0] DIV_SEL1 = 8'h56;
    localparam logic [7:0] DIV_SEL2 = 8'h56;
    localparam logic [7:0] DIV_SEL3 = 8'h42;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic prescaled_tick;
        logic transfer_tick;
        logic prohibited;
    } sbp_clk_t;
endpackage

//--- hdl/sbp_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// RQ1: Bit 4 of the prescaler select register enables the first divider.
// RQ2: Bits 3 and 1:0 pick main clock /2../5, or undivided when bit 3 is set.
// RQ3: The option bit doubles every first-stage ratio.
// RQ4: The prescaled clock drives a second divider giving the transfer clock.
// RQ5: Software keeps the prescaled clock between 1 MHz and 10 MHz.
// RQ6: Option bit and speed mode bit pick one of four rate tables.
// RQ7: Standard table: sel 00 /44, 01 /86, 11 /66, 10 main /86; rest barred.
// RQ8: The prescaler select register resets to all zeros.
// RQ9: Bits 7, 6, 5 and 2 of the prescaler select register read as zero.
// RQ10: The clock extension bit is bit 0 of the function expansion register.
// RQ11: With the first stage disabled no clock ticks are produced.
module sbp_prescaler (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [sbp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [sbp_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [sbp_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [sbp_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output sbp_pkg::sbp_clk_t clk_out
);
    import sbp_pkg::*;

    logic [7:0] bus_prescaler_select;
    logic [7:0] bus_clock_select_reg;
    logic [7:0] function_expansion_reg;
    logic prescale_option_bit;
    logic [ADDR_W-1:0] aw_addr;
    logic aw_held;
    logic [DATA_W-1:0] w_data;
    logic w_strb0;
    logic w_held;
    logic [3:0] pre_cnt;
    logic [3:0] pre_div;
    logic [7:0] tc_cnt;
    logic [7:0] tc_div;
    logic prescaler_enable_bit;
    logic prescaler_high_select;
    logic [1:0] prescaler_ratio_field;
    logic [1:0] clock_select_field;
    logic speed_mode_bit;
    logic clock_extension_bit;
    logic prescaled_bus_clock;
    logic stage_tick;
    logic table_ok;
    logic do_write;
    logic [7:0] wbyte;
    sbp_clk_t next_clk;

    assign prescaler_enable_bit = bus_prescaler_select[ENABLE_BIT];
    assign prescaler_high_select = bus_prescaler_select[HIGH_BIT];
    assign prescaler_ratio_field = bus_prescaler_select[RATIO_LSB +: 2];
    assign clock_select_field = bus_clock_select_reg[CLKSEL_LSB +: 2];
    assign speed_mode_bit = bus_clock_select_reg[SPEED_BIT];
    assign clock_extension_bit = function_expansion_reg[EXT_BIT]; // [RQ10]
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wbyte = w_data[7:0];

    // AXI write: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb0 <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == PRESCALER_ADDR ||
                            aw_addr == CLKSEL_ADDR ||
                            aw_addr == EXPAND_ADDR ||
                            aw_addr == OPTION_ADDR) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register file; only byte lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_prescaler_select <= PRESCALER_RESET; // [RQ8]
            bus_clock_select_reg <= 8'h00;
            function_expansion_reg <= 8'h00;
            prescale_option_bit <= 1'b0;
        end else if (do_write && w_strb0) begin
            unique case (aw_addr)
                PRESCALER_ADDR:
                    bus_prescaler_select <= wbyte & PRESCALER_WMASK; // [RQ9]
                CLKSEL_ADDR: bus_clock_select_reg <= wbyte & CLKSEL_WMASK;
                EXPAND_ADDR: function_expansion_reg <= {7'h00, wbyte[EXT_BIT]};
                // Option byte stands in for the factory option load
                OPTION_ADDR: prescale_option_bit <= wbyte[OPTION_BIT]; // [RQ3]
                default: ;
            endcase
        end
    end

    // AXI read, one outstanding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                PRESCALER_ADDR: s_axi_rdata <= {24'h0, bus_prescaler_select};
                CLKSEL_ADDR: s_axi_rdata <= {24'h0, bus_clock_select_reg};
                EXPAND_ADDR: s_axi_rdata <= {24'h0, function_expansion_reg};
                OPTION_ADDR: s_axi_rdata <= {31'h0, prescale_option_bit};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // First stage ratio; doubled by the option bit
    always_comb begin
        if (prescaler_high_select) begin
            pre_div = 4'h1; // [RQ2]
        end else begin
            pre_div = {2'b00, prescaler_ratio_field} + 4'h2; // [RQ2]
        end
        if (prescale_option_bit) begin
            pre_div = {pre_div[2:0], 1'b0}; // [RQ3]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !prescaler_enable_bit) begin
            pre_cnt <= 4'h0; // [RQ1] [RQ11]
        end else if (pre_cnt >= pre_div - 4'h1) begin
            pre_cnt <= 4'h0;
        end else begin
            pre_cnt <= pre_cnt + 4'h1;
        end
    end

    assign prescaled_bus_clock = prescaler_enable_bit &&
                                 (pre_cnt >= pre_div - 4'h1); // [RQ1]

    // Only the documented table (standard, option clear) is filled in
    always_comb begin
        table_ok = !speed_mode_bit && !prescale_option_bit &&
                   !clock_extension_bit; // [RQ6]
        stage_tick = prescaled_bus_clock;
        unique case (clock_select_field)
            2'b00: tc_div = DIV_SEL0; // [RQ7]
            2'b01: tc_div = DIV_SEL1; // [RQ7]
            2'b10: begin
                tc_div = DIV_SEL2; // [RQ7]
                // Bypasses stage one, still held off by the enable
                stage_tick = prescaler_enable_bit;
            end
            default: tc_div = DIV_SEL3; // [RQ7]
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !prescaler_enable_bit || !table_ok) begin
            tc_cnt <= 8'h00; // [RQ11]
        end else if (stage_tick) begin
            tc_cnt <= (tc_cnt >= tc_div - 8'h01) ? 8'h00 :
                      tc_cnt + 8'h01; // [RQ4]
        end
    end

    always_comb begin
        next_clk.prescaled_tick = prescaled_bus_clock;
        next_clk.transfer_tick = table_ok && stage_tick &&
                                 (tc_cnt >= tc_div - 8'h01); // [RQ4]
        next_clk.prohibited = !table_ok;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_out <= '0;
        end else begin
            clk_out <= next_clk;
        end
    end
    property p_disabled_quiet;
        @(posedge aclk) disable iff (!aresetn)
        !prescaler_enable_bit [*2] |=> !clk_out.prescaled_tick &&
                                        !clk_out.transfer_tick;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) // [RQ11]
        else $error("tick while disabled");
    property p_reserved_zero;
        @(posedge aclk) disable iff (!aresetn)
        bus_prescaler_select[7:5] == 3'b000 && !bus_prescaler_select[2];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // [RQ9]
        else $error("reserved bit set");
    property p_div2;
        @(posedge aclk) disable iff (!aresetn)
        (prescaler_enable_bit && !prescale_option_bit &&
         bus_prescaler_select[3:0] == 4'h0 && prescaled_bus_clock) [*1]
        ##1 (bus_prescaler_select[4:0] == 5'h10 &&
             !$changed(prescale_option_bit))
        |-> !prescaled_bus_clock;
    endproperty
    a_div2: assert property (p_div2) // [RQ2]
        else $error("divide by two wrong");
    property p_undiv;
        @(posedge aclk) disable iff (!aresetn)
        prescaler_enable_bit && prescaler_high_select &&
        !prescale_option_bit |-> prescaled_bus_clock;
    endproperty
    a_undiv: assert property (p_undiv) // [RQ2]
        else $error("undivided clock missing tick");
    // A legal option change may restore the undivided clock at once
    property p_option_double;
        @(posedge aclk) disable iff (!aresetn)
        prescaler_enable_bit && prescale_option_bit &&
        prescaler_high_select && $stable(bus_prescaler_select) &&
        prescaled_bus_clock |=> !prescaled_bus_clock ||
                                $changed(prescale_option_bit);
    endproperty
    a_option_double: assert property (p_option_double) // [RQ3]
        else $error("option did not double ratio");
    property p_prohibited;
        @(posedge aclk) disable iff (!aresetn)
        (speed_mode_bit || clock_extension_bit) |=> !clk_out.transfer_tick;
    endproperty
    a_prohibited: assert property (p_prohibited) // [RQ6]
        else $error("tick from prohibited table");
    // A shrinking divisor may leave the count high until its next wrap
    property p_tc_bound;
        @(posedge aclk) disable iff (!aresetn)
        tc_cnt < tc_div |=> tc_cnt < tc_div || $changed(tc_div);
    endproperty
    a_tc_bound: assert property (p_tc_bound) // [RQ7]
        else $error("second stage count out of range");
    property p_tick_spacing;
        @(posedge aclk) disable iff (!aresetn)
        clk_out.transfer_tick |=> (!clk_out.transfer_tick) [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) // [RQ4]
        else $error("transfer ticks too close");
endmodule
`default_nettype wire

//--- sim/test_serial_bus_rate_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module test_serial_bus_rate_prescaler;
    import sbp_pkg::*;
    logic aclk = 0, aresetn = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
    logic [3:0] wstrb = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    sbp_clk_t clk_out;
    int fail_count = 0, n_checks = 0, np, nt;
    // Rows keep the prescaled clock at 1 to 10 MHz
    logic [7:0] pre_t [6] = '{8'h10, 8'h11, 8'h13, 8'h10, 8'h12, 8'h12};
    logic [7:0] sel_t [6] = '{8'h00, 8'h01, 8'h00, 8'h03, 8'h02, 8'h01};
    int ps_t [6] = '{2, 3, 5, 2, 4, 4};
    int tt_t [6] = '{88, 258, 220, 132, 86, 344};

    sbp_prescaler i_sbp_prescaler (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .clk_out(clk_out)
    );

    always #25 aclk = ~aclk;

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Holds each channel until its ready
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1;
                awvalid <= 0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1;
                wvalid <= 0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 0;
        chk(bresp, er, "write response");
        @(posedge aclk);
    endtask

    task rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rready <= 0;
        chk(rresp, er, "read response");
        if (er == RESP_OKAY) chk(rdata, ed, "read data");
        @(posedge aclk);
    endtask

    task count(input int w);
        np = 0;
        nt = 0;
        repeat (w) begin
            @(posedge aclk);
            if (clk_out.prescaled_tick === 1'b1) np++;
            if (clk_out.transfer_tick === 1'b1) nt++;
        end
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #3000000;
        fail_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        rd(PRESCALER_ADDR, 32'h0, RESP_OKAY);
        wr(CLKSEL_ADDR, 32'h0, 4'hf, RESP_OKAY);
        wr(PRESCALER_ADDR, 32'h03, 4'hf, RESP_OKAY);
        count(400);
        chk(np + nt, 0, "ticks while disabled");
        wr(PRESCALER_ADDR, 32'hf7, 4'hf, RESP_OKAY);
        rd(PRESCALER_ADDR, 32'h13, RESP_OKAY);
        // Lane 0 off: write ignored
        wr(PRESCALER_ADDR, 32'h00, 4'he, RESP_OKAY);
        rd(PRESCALER_ADDR, 32'h13, RESP_OKAY);
        rd(32'h0ffff350, 32'h0, RESP_SLVERR);
        wr(32'h0ffff350, 32'h0, 4'hf, RESP_SLVERR);
        for (int i = 0; i < 6; i++) begin
            wr(PRESCALER_ADDR, {24'h0, pre_t[i]}, 4'hf, RESP_OKAY);
            wr(CLKSEL_ADDR, {24'h0, sel_t[i]}, 4'hf, RESP_OKAY);
            count(700);
            count(2 * tt_t[i]);
            chk(np, 2 * tt_t[i] / ps_t[i], "prescaled ticks");
            chk(nt, 2, "transfer ticks");
            chk(clk_out.prohibited, 1'b0, "valid table");
        end
        // Each leaves the supported table
        for (int k = 0; k < 3; k++) begin
            wr(OPTION_ADDR, (k == 2), 4'hf, RESP_OKAY);
            wr(PRESCALER_ADDR, (k == 2) ? 32'h18 : 32'h10, 4'hf, RESP_OKAY);
            wr(CLKSEL_ADDR, (k == 0) ? 32'h08 : 32'h0, 4'hf, RESP_OKAY);
            wr(EXPAND_ADDR, (k == 1), 4'hf, RESP_OKAY);
            count(400);
            chk(np, 200, "prescaled ticks");
            chk(clk_out.prohibited, 1'b1, "prohibited flag");
            chk(nt, 0, "no transfer ticks");
        end
        aresetn <= 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        rd(PRESCALER_ADDR, 32'h0, RESP_OKAY);
        print_verdict();
    end
endmodule
`default_nettype wire
